// [nsf_pkg.sv]
package nsf_pkg;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [31:0] NSF_ADDR_STATUS = 32'hfc05_c008;
    localparam logic [31:0] NSF_ADDR_COEFF0 = 32'hfc05_c528;
    localparam logic [31:0] NSF_ADDR_IRQ_STS = 32'hfc05_c0f0;
    localparam logic [31:0] NSF_ADDR_IRQ_MSK = 32'hfc05_c0f4;
    localparam logic [31:0] NSF_ADDR_TIMEOUT = 32'hfc05_c0f8;

    // =====================================================================
    // status field positions
    localparam int NSF_B_ENABLED = 0;
    localparam int NSF_B_RISE = 4;
    localparam int NSF_B_FALL = 5;
    localparam int NSF_B_ACTIVE = 8;
    localparam int NSF_B_DIR = 11;
    localparam int NSF_B_CS_LO = 12;
    localparam int NSF_B_XFER = 16;
    localparam int NSF_B_CMD = 17;
    localparam int NSF_B_DATA_TIMEOUT_ERROR = 20;
    localparam int NSF_B_UNMAPPED_AREA_ERROR = 21;
    localparam int NSF_B_AWB = 22;

    // clear-on-read event flags of the status word
    localparam logic [31:0] NSF_FLAG_MASK = 32'h0073_0030;

    // timeout register fields
    localparam int NSF_TO_CYC_LO = 0;
    localparam int NSF_TO_MUL_LO = 4;
    localparam logic [31:0] NSF_TO_RESET = 32'h0000_0000;
    localparam int NSF_TO_CNT_W = 20;

    // coefficient widths per sector size
    localparam int NSF_COEFF_W_512 = 13;
    localparam int NSF_COEFF_W_1024 = 14;

    // axi responses
    localparam logic [1:0] NSF_RESP_OKAY = 2'b00;
    localparam logic [1:0] NSF_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } nsf_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } nsf_axi_rsp_t;

    // events and state reported by the command unit
    typedef struct packed {
        logic enabled;
        logic active;
        logic cmd_issue;
        logic cmd_write;
        logic [2:0] cmd_cs;
        logic xfer_done;
        logic cmd_done;
        logic data_wait;
        logic unmapped_area_error_access;
        logic busy_access;
        logic sector_1024;
        logic [13:0] coeff0;
    } nsf_unit_t;

    typedef struct packed {
        nsf_axi_rsp_t axi;
        logic have_aw;
        logic [31:0] aw_addr;
        logic have_w;
        logic [31:0] w_data;
        logic [31:0] flags;
        logic [31:0] irq_sts;
        logic [31:0] irq_msk;
        logic [31:0] timeout_cfg;
        logic [NSF_TO_CNT_W-1:0] to_cnt;
        logic to_fired;
        logic [7:0] rb_prev;
        logic enabled;
        logic active;
        logic dir;
        logic [2:0] cs;
        logic irq;
    } nsf_state_t;

endpackage

// [nsf_top.sv]
`timescale 1ns/1ps

// Summary of operation
// - enabled bit mirrors unit enable, reset-proof
// - bit 4 set on selected ready rise
// - bit 5 set on selected ready fall
// - chip-select field picks monitored ready line
// - status read clears edge, done, error flags
// - bit 8 shows unit active, reset-proof
// - bit 11 shows command direction, reset-proof
// - bits 14:12 hold command chip-select, reset-proof
// - bit 16 set when transfer finishes
// - bit 17 set when command finishes
// - bit 20 set on data timeout exceeded
// - bit 21 set on undefined area access
// - bit 22 set on access while busy
// - coefficient 13 bits for 512-byte sectors
// - coefficient 14 bits for 1024-byte sectors
module nsf_top #(
    parameter int NUM_CS = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire nsf_pkg::nsf_axi_req_t axi_req,
    output nsf_pkg::nsf_axi_rsp_t axi_rsp,
    input wire nsf_pkg::nsf_unit_t unit,
    input wire logic [NUM_CS-1:0] ready_busy,
    output logic irq
);
    import nsf_pkg::*;

    nsf_state_t r;
    nsf_state_t next_r;
    logic [31:0] ev;
    logic [31:0] status_word;
    logic [31:0] coeff_word;
    logic [7:0] rb_now;
    logic rb_sel_now;
    logic rb_sel_prev;
    logic [NSF_TO_CNT_W-1:0] to_limit;
    logic [2:0] to_mul;
    logic [3:0] to_cyc;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;

    // =====================================================================
    // address decode
    function automatic logic is_mapped(input logic [31:0] a);
        if (a == NSF_ADDR_STATUS) begin
            return 1'b1;
        end else if (a == NSF_ADDR_COEFF0) begin
            return 1'b1;
        end else if (a == NSF_ADDR_IRQ_STS) begin
            return 1'b1;
        end else if (a == NSF_ADDR_IRQ_MSK) begin
            return 1'b1;
        end else if (a == NSF_ADDR_TIMEOUT) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                res[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // =====================================================================
    // ready line selection and timeout limit
    always_comb begin
        rb_now = 8'h00;
        rb_now[NUM_CS-1:0] = ready_busy;
        rb_sel_now = rb_now[r.cs];
        rb_sel_prev = r.rb_prev[r.cs];
        to_cyc = r.timeout_cfg[NSF_TO_CYC_LO +: 4];
        to_mul = r.timeout_cfg[NSF_TO_MUL_LO +: 3];
        // limit = (cycles + 1) scaled by 4 per multiplier step
        to_limit = NSF_TO_CNT_W'({16'h0000, 4'(to_cyc)} + 20'h0_0001) << (2 * to_mul);
    end

    // =====================================================================
    // read-only views
    always_comb begin
        status_word = r.flags;
        status_word[NSF_B_ENABLED] = r.enabled;
        status_word[NSF_B_ACTIVE] = r.active;
        status_word[NSF_B_DIR] = r.dir;
        status_word[NSF_B_CS_LO +: 3] = r.cs;
        coeff_word = 32'h0000_0000;
        if (unit.sector_1024) begin
            coeff_word[NSF_COEFF_W_1024-1:0] = unit.coeff0;
        end else begin
            coeff_word[NSF_COEFF_W_512-1:0] = unit.coeff0[NSF_COEFF_W_512-1:0];
        end
    end

    // =====================================================================
    // next state
    always_comb begin
        next_r = r;
        ev = 32'h0000_0000;
        rd_word = 32'h0000_0000;
        rd_ok = is_mapped(axi_req.araddr);
        wr_ok = is_mapped(r.aw_addr);

        next_r.enabled = unit.enabled;
        next_r.active = unit.active;
        if (unit.cmd_issue) begin
            next_r.dir = unit.cmd_write;
            next_r.cs = unit.cmd_cs;
        end
        next_r.rb_prev = rb_now;

        // data timeout counter, one event per wait
        if (!unit.data_wait) begin
            next_r.to_cnt = '0;
            next_r.to_fired = 1'b0;
        end else if (!r.to_fired) begin
            if (r.to_cnt >= to_limit) begin
                next_r.to_fired = 1'b1;
                ev[NSF_B_DATA_TIMEOUT_ERROR] = 1'b1;
            end else begin
                next_r.to_cnt = r.to_cnt + NSF_TO_CNT_W'(1);
            end
        end

        ev[NSF_B_RISE] = rb_sel_now & ~rb_sel_prev;
        ev[NSF_B_FALL] = ~rb_sel_now & rb_sel_prev;
        ev[NSF_B_XFER] = unit.xfer_done;
        ev[NSF_B_CMD] = unit.cmd_done;
        ev[NSF_B_UNMAPPED_AREA_ERROR] = unit.unmapped_area_error_access;
        ev[NSF_B_AWB] = unit.busy_access;

        // ---- read channel
        if (r.axi.rvalid && axi_req.rready) begin
            next_r.axi.rvalid = 1'b0;
        end
        next_r.axi.arready = 1'b0;
        if (r.axi.arready && axi_req.arvalid) begin
            if (axi_req.araddr == NSF_ADDR_STATUS) begin
                rd_word = status_word;
                next_r.flags = r.flags & ~NSF_FLAG_MASK;
            end else if (axi_req.araddr == NSF_ADDR_COEFF0) begin
                rd_word = coeff_word;
            end else if (axi_req.araddr == NSF_ADDR_IRQ_STS) begin
                rd_word = r.irq_sts;
            end else if (axi_req.araddr == NSF_ADDR_IRQ_MSK) begin
                rd_word = r.irq_msk;
            end else if (axi_req.araddr == NSF_ADDR_TIMEOUT) begin
                rd_word = r.timeout_cfg;
            end
            next_r.axi.rdata = rd_word;
            next_r.axi.rresp = rd_ok ? NSF_RESP_OKAY : NSF_RESP_SLVERR;
            next_r.axi.rvalid = 1'b1;
        end else if (!next_r.axi.rvalid && !r.axi.arready) begin
            next_r.axi.arready = 1'b1;
        end

        // ---- write channels, either order
        if (r.axi.awready && axi_req.awvalid) begin
            next_r.have_aw = 1'b1;
            next_r.aw_addr = axi_req.awaddr;
        end
        if (r.axi.wready && axi_req.wvalid) begin
            next_r.have_w = 1'b1;
            next_r.w_data = strb_merge(32'h0000_0000, axi_req.wdata, axi_req.wstrb);
        end
        if (r.axi.bvalid && axi_req.bready) begin
            next_r.axi.bvalid = 1'b0;
        end
        if (r.have_aw && r.have_w && !r.axi.bvalid) begin
            // status and coefficient fall through untouched
            if (r.aw_addr == NSF_ADDR_IRQ_STS) begin
                next_r.irq_sts = r.irq_sts & ~r.w_data;
            end else if (r.aw_addr == NSF_ADDR_IRQ_MSK) begin
                next_r.irq_msk = r.w_data;
            end else if (r.aw_addr == NSF_ADDR_TIMEOUT) begin
                next_r.timeout_cfg = r.w_data & 32'h0000_007f;
            end
            next_r.have_aw = 1'b0;
            next_r.have_w = 1'b0;
            next_r.axi.bresp = wr_ok ? NSF_RESP_OKAY : NSF_RESP_SLVERR;
            next_r.axi.bvalid = 1'b1;
        end
        next_r.axi.awready = !next_r.have_aw && !next_r.axi.bvalid;
        next_r.axi.wready = !next_r.have_w && !next_r.axi.bvalid;

        // set wins over any clear in the same cycle
        next_r.flags = next_r.flags | (ev & NSF_FLAG_MASK);
        next_r.irq_sts = next_r.irq_sts | (ev & NSF_FLAG_MASK);
        next_r.irq = |(next_r.irq_sts & next_r.irq_msk);

        // reset leaves enabled, active, dir and cs alone
        if (!rst_n) begin
            next_r.axi = '0;
            next_r.have_aw = 1'b0;
            next_r.aw_addr = 32'h0000_0000;
            next_r.have_w = 1'b0;
            next_r.w_data = 32'h0000_0000;
            next_r.flags = 32'h0000_0000;
            next_r.irq_sts = 32'h0000_0000;
            next_r.irq_msk = 32'h0000_0000;
            next_r.timeout_cfg = NSF_TO_RESET;
            next_r.to_cnt = '0;
            next_r.to_fired = 1'b0;
            next_r.irq = 1'b0;
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    assign axi_rsp = r.axi;
    assign irq = r.irq;

endmodule

// [nsf_checker.sv]
`timescale 1ns/1ps
module nsf_checker
    import nsf_pkg::*;
#(
    parameter int NUM_CS = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire nsf_pkg::nsf_axi_req_t axi_req,
    input wire nsf_pkg::nsf_axi_rsp_t axi_rsp,
    input wire nsf_pkg::nsf_unit_t unit,
    input wire logic [NUM_CS-1:0] ready_busy,
    input wire logic irq
);
    // ====================
    // read address tracking
    logic [31:0] last_ar;
    logic mapped;
    always_ff @(posedge ref_clk) begin
        if (axi_req.arvalid && axi_rsp.arready) begin
            last_ar <= axi_req.araddr;
        end
    end
    assign mapped = last_ar inside {NSF_ADDR_STATUS, NSF_ADDR_COEFF0, NSF_ADDR_IRQ_STS,
        NSF_ADDR_IRQ_MSK, NSF_ADDR_TIMEOUT};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rd_answer;
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
    endproperty
    property p_wr_answer;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
            |=> (!axi_rsp.awready && !axi_rsp.wready) ##[0:1] axi_rsp.bvalid;
    endproperty
    property p_rvalid_hold;
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
    endproperty
    property p_bvalid_hold;
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
    endproperty
    property p_unmapped;
        $rose(axi_rsp.rvalid) && !mapped |-> axi_rsp.rresp == NSF_RESP_SLVERR && axi_rsp.rdata == 0;
    endproperty
    property p_mapped_ok;
        $rose(axi_rsp.rvalid) && mapped |-> axi_rsp.rresp == NSF_RESP_OKAY;
    endproperty
    property p_coeff_512;
        $rose(axi_rsp.rvalid) && last_ar == NSF_ADDR_COEFF0 && !unit.sector_1024
            && $stable(unit.coeff0) && $stable(unit.sector_1024)
            |-> axi_rsp.rdata == {19'h0, unit.coeff0[12:0]};
    endproperty
    property p_coeff_1024;
        $rose(axi_rsp.rvalid) && last_ar == NSF_ADDR_COEFF0 && unit.sector_1024
            && $stable(unit.coeff0) && $stable(unit.sector_1024)
            |-> axi_rsp.rdata == {18'h0, unit.coeff0};
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
    a_coeff_512: assert property (p_coeff_512) else $error("coeff wrong for 512");
    a_coeff_1024: assert property (p_coeff_1024) else $error("coeff wrong for 1024");
    c_status_rd: cover property ($rose(axi_rsp.rvalid) && last_ar == NSF_ADDR_STATUS);
    c_unmapped: cover property ($rose(axi_rsp.rvalid) && !mapped);
    c_irq: cover property ($rose(irq));
endmodule
bind nsf_top nsf_checker #(.NUM_CS(NUM_CS)) u_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .unit(unit), .ready_busy(ready_busy), .irq(irq));

// [nsf_flash_model.sv]
`timescale 1ns/1ps
module nsf_flash_model #(
    parameter int BUSY_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic [2:0] busy_cs,
    input wire logic busy_go,
    output logic [7:0] ready_busy
);
    // ====================
    // busy period, lines pulled up when ready
    int cnt = 0;
    logic [2:0] sel = 3'h0;
    always_ff @(posedge ref_clk) begin
        if (busy_go) begin
            sel <= busy_cs;
            cnt <= BUSY_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    always_comb begin
        ready_busy = 8'hff;
        if (cnt != 0) begin
            ready_busy[sel] = 1'b0;
        end
    end
endmodule

// [tb_nand_ctrl_status_flags.sv]
`timescale 1ns/1ps
module tb_nand_ctrl_status_flags;
    import nsf_pkg::*;
    logic ref_clk = 0;
    logic rst_n = 0;
    nsf_axi_req_t req = '0;
    nsf_axi_rsp_t rsp;
    nsf_unit_t unit = '0;
    logic [7:0] ready_busy;
    logic irq;
    logic busy_go = 0;
    logic [2:0] busy_cs = 3'h0;
    logic [31:0] d;
    logic [1:0] r;
    int err_count = 0;
    int cmp_count = 0;
    always #4 ref_clk = ~ref_clk;
    nsf_top #(.NUM_CS(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .axi_req(req),
        .axi_rsp(rsp), .unit(unit), .ready_busy(ready_busy), .irq(irq));
    nsf_flash_model model (.ref_clk(ref_clk), .busy_cs(busy_cs), .busy_go(busy_go),
        .ready_busy(ready_busy));
    // ====================
    // bus and check helpers
    task tally_and_finish;
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 100) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        int n;
        logic ta;
        logic tw;
        n = 0;
        ta = 0;
        tw = 0;
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.awvalid <= 1;
        req.wvalid <= 1;
        while (!(ta && tw)) begin
            tick(1);
            guard(n);
            if (!ta && rsp.awready === 1'b1) begin
                ta = 1;
                req.awvalid <= 0;
            end
            if (!tw && rsp.wready === 1'b1) begin
                tw = 1;
                req.wvalid <= 0;
            end
        end
        req.bready <= 1;
        do begin
            tick(1);
            guard(n);
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 0;
        tick(2);
    endtask
    task automatic rd(input logic [31:0] a, input logic ev);
        int n;
        n = 0;
        req.araddr <= a;
        req.arvalid <= 1;
        req.rready <= 1;
        unit.cmd_done <= ev;
        do begin
            tick(1);
            guard(n);
        end while (rsp.arready !== 1'b1);
        req.arvalid <= 0;
        unit.cmd_done <= 0;
        do begin
            tick(1);
            guard(n);
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 0;
        tick(3);
    endtask
    task pulse(input logic [3:0] m);
        {unit.xfer_done, unit.cmd_done, unit.unmapped_area_error_access, unit.busy_access} <= m;
        tick(1);
        {unit.xfer_done, unit.cmd_done, unit.unmapped_area_error_access, unit.busy_access} <= 4'h0;
        tick(1);
    endtask
    task busy(input logic [2:0] cs);
        busy_cs <= cs;
        busy_go <= 1;
        tick(1);
        busy_go <= 0;
        tick(8);
    endtask
    // ====================
    // scenarios
    task s_clean;
        unit.enabled <= 1;
        unit.active <= 1;
        tick(3);
        rd(NSF_ADDR_STATUS, 0);
        check(d & 32'h0073_0131, 32'h0000_0101);
    endtask
    task s_edges;
        unit.cmd_write <= 1;
        unit.cmd_cs <= 3'h3;
        unit.cmd_issue <= 1;
        tick(1);
        unit.cmd_issue <= 0;
        busy(3'h5);
        rd(NSF_ADDR_STATUS, 0);
        check(d & 32'h0000_7830, 32'h0000_3800);
        busy(3'h3);
        rd(NSF_ADDR_STATUS, 0);
        check(d & 32'h0000_0030, 32'h0000_0030);
        rd(NSF_ADDR_STATUS, 0);
        check(d & 32'h0000_0030, 32'h0000_0000);
    endtask
    task s_reset_keep;
        rst_n <= 0;
        tick(2);
        rst_n <= 1;
        tick(3);
        rd(NSF_ADDR_STATUS, 0);
        check(d & 32'h0000_7901, 32'h0000_3901);
        unit.enabled <= 0;
        unit.active <= 0;
        tick(3);
        rd(NSF_ADDR_STATUS, 0);
        check(d & 32'h0000_0101, 32'h0000_0000);
    endtask
    task s_events;
        wr(NSF_ADDR_TIMEOUT, 32'h0000_0001);
        unit.data_wait <= 1;
        tick(8);
        unit.data_wait <= 0;
        pulse(4'hf);
        rd(NSF_ADDR_STATUS, 0);
        check(d & NSF_FLAG_MASK, 32'h0073_0000);
        rd(NSF_ADDR_STATUS, 0);
        check(d & NSF_FLAG_MASK, 32'h0000_0000);
        rd(NSF_ADDR_STATUS, 1);
        rd(NSF_ADDR_STATUS, 0);
        check(d & NSF_FLAG_MASK, 32'h0002_0000);
    endtask
    task s_irq;
        // drop events left by earlier scenarios
        wr(NSF_ADDR_IRQ_STS, 32'hffff_ffff);
        wr(NSF_ADDR_IRQ_MSK, 32'h0002_0000);
        pulse(4'h8);
        check({31'h0, irq}, 32'h0000_0000);
        pulse(4'h4);
        check({31'h0, irq}, 32'h0000_0001);
        rd(NSF_ADDR_IRQ_STS, 0);
        check(d, 32'h0003_0000);
        wr(NSF_ADDR_IRQ_STS, 32'h0002_0000);
        check({31'h0, irq}, 32'h0000_0000);
        rd(NSF_ADDR_IRQ_STS, 0);
        check(d, 32'h0001_0000);
    endtask
    task s_read_only;
        unit.coeff0 <= 14'h3fff;
        rd(NSF_ADDR_STATUS, 0);
        wr(NSF_ADDR_STATUS, 32'hffff_ffff);
        check({30'h0, r}, {30'h0, NSF_RESP_OKAY});
        wr(NSF_ADDR_COEFF0, 32'hffff_ffff);
        rd(NSF_ADDR_STATUS, 0);
        check(d & NSF_FLAG_MASK, 32'h0000_0000);
        rd(NSF_ADDR_COEFF0, 0);
        check(d, 32'h0000_1fff);
        unit.sector_1024 <= 1;
        tick(2);
        rd(NSF_ADDR_COEFF0, 0);
        check(d, 32'h0000_3fff);
        rd(32'hfc05_c100, 0);
        check({30'h0, r} | d, {30'h0, NSF_RESP_SLVERR});
        wr(32'hfc05_c100, 32'hffff_ffff);
        check({30'h0, r}, {30'h0, NSF_RESP_SLVERR});
    endtask
    initial begin
        tick(8);
        // latch a known chip-select inside reset, it survives reset
        unit.cmd_issue <= 1;
        tick(1);
        unit.cmd_issue <= 0;
        tick(1);
        rst_n <= 1;
        tick(3);
        s_clean();
        s_edges();
        s_reset_keep();
        s_events();
        s_irq();
        s_read_only();
        tally_and_finish();
    end
endmodule
